/* rtl/cprm_pkg.sv */
package cprm_pkg;

  // ===========================================================================
  // Widths and storage map
  // ===========================================================================
  localparam int          XLEN         = 32;
  localparam int          EXT_ADDR_W   = 24;
  localparam int          MEM_AW       = 5;
  localparam int          MEM_DEPTH    = 32;
  localparam int          LANES        = 4;
  localparam int          FC_W         = 3;
  localparam logic [4:0]  MEM_USP      = 5'h0f;
  localparam logic [4:0]  MEM_SSP      = 5'h10;
  localparam logic [3:0]  IDX_STACK    = 4'hf;
  localparam logic [3:0]  LANE_BYTE    = 4'h1;
  localparam logic [3:0]  LANE_WORD    = 4'h3;
  localparam logic [3:0]  LANE_LONG    = 4'hf;
  localparam int          VEC_SHIFT    = 2;
  localparam int          ADDR_REG_BIT = 3;

  // ===========================================================================
  // Status word layout
  // ===========================================================================
  localparam int           SR_T1_BIT    = 15;
  localparam int           SR_T0_BIT    = 14;
  localparam int           SR_S_BIT     = 13;
  localparam int           SR_IPM_LSB   = 8;
  localparam int           SR_IPM_MSB   = 10;
  localparam int           CCR_MSB      = 7;
  localparam int           SR_Z_BIT     = 2;
  // Implemented bits: both trace bits, the privilege bit, the mask and the five flags.
  localparam logic [15:0]  SR_IMPL      = 16'he71f;
  localparam logic [15:0]  SR_RESET     = 16'h2700;
  localparam logic [31:0]  VBR_RESET    = 32'h0000_0000;
  localparam logic [31:0]  PC_RESET     = 32'h0000_0000;

  // ===========================================================================
  // Function codes
  // ===========================================================================
  localparam logic [2:0]  FC_RESET     = 3'h0;
  localparam logic [2:0]  FC_CPU       = 3'h7;
  localparam logic [1:0]  FC_DATA      = 2'h1;
  localparam logic [1:0]  FC_PROG      = 2'h2;

  // ===========================================================================
  // Command encodings
  // ===========================================================================
  typedef enum logic [3:0] {
    OP_RD_GPR, OP_WR_GPR, OP_BIT, OP_RD_CTL, OP_WR_CTL, OP_RD_CCR, OP_WR_CCR,
    OP_CHECK_INSN, OP_PC_ADV, OP_PC_LOAD, OP_EXC, OP_EXC_DONE, OP_BGND
  } cprm_op_e;

  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG, SZ_QUAD} cprm_size_e;
  typedef enum logic [2:0] {CTL_USP, CTL_SSP, CTL_SR, CTL_VBR, CTL_SFC, CTL_DFC} cprm_ctl_e;
  typedef enum logic [1:0] {BIT_TEST, BIT_CHG, BIT_CLR, BIT_SET} cprm_bitop_e;
  typedef enum logic [1:0] {ST_RUN, ST_RMW, ST_QUAD, ST_STOP} cprm_state_e;

  typedef struct packed {
    cprm_op_e    op;
    cprm_size_e  size;
    logic [3:0]  idx;
    logic [3:0]  idx_hi;
    cprm_ctl_e   ctl;
    cprm_bitop_e bitop;
    logic        priv_insn;
    logic [31:0] wdata;
    logic [31:0] wdata_hi;
  } cprm_req_s;

  typedef struct packed {
    logic        valid;
    logic        fault;
    logic [31:0] data;
  } cprm_rsp_s;

  typedef struct packed {
    logic        valid;
    logic        prog;
    logic        cpu;
    logic        alt_src;
    logic        alt_dst;
    logic [31:0] base;
    logic [31:0] disp;
  } cprm_acc_s;

  typedef struct packed {
    logic        valid;
    logic        fault;
    logic [2:0]  fc;
    logic [23:0] addr;
  } cprm_bus_s;

endpackage

/* rtl/cprm_regmem.sv */
`timescale 1ns/1ns
module cprm_regmem
  import cprm_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    we,
  input  wire logic [cprm_pkg::LANES-1:0]  be,
  input  wire logic [cprm_pkg::MEM_AW-1:0] waddr,
  input  wire logic [31:0]             wdata,
  input  wire logic [cprm_pkg::MEM_AW-1:0] raddr,
  output logic      [31:0]             rdata_ff
);

  // ===========================================================================
  // Storage with one lane enable per byte
  // ===========================================================================
  // Contents are undefined after reset, as the architecture leaves them.
  // Each lane owns its own array so that no two processes write one variable.
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    logic [7:0] lane_mem [MEM_DEPTH];

    always_ff @(posedge clk) begin
      if (we && be[g]) begin
        lane_mem[waddr] <= wdata[g*8 +: 8];
      end
      rdata_ff[g*8 +: 8] <= lane_mem[raddr];
    end
  end

endmodule

/* rtl/cprm_core.sv */
`timescale 1ns/1ns
module cprm_core
  import cprm_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic                  req_valid,
  input  wire cprm_pkg::cprm_req_s   req,
  output logic                       req_ready,
  output cprm_pkg::cprm_rsp_s        rsp_ff,
  input  wire cprm_pkg::cprm_acc_s   acc,
  output cprm_pkg::cprm_bus_s        bus_ff,
  input  wire logic                  bus_err,
  input  wire logic                  bkpt_hit,
  input  wire logic                  bgnd_enable,
  input  wire logic                  bgnd_resume,
  output logic [15:0]                status_word_ff,
  output logic [31:0]                pc_ff,
  output logic                       supervisor,
  output logic                       halted_ff,
  output logic                       in_background_ff
);

  // ===========================================================================
  // State
  // ===========================================================================
  cprm_state_e  state_ff,        nxt_state;
  logic [31:0]  vbr_ff,          nxt_vbr;
  logic [2:0]   sfc_ff,          nxt_sfc;
  logic [2:0]   dfc_ff,          nxt_dfc;
  logic [15:0]  nxt_status_word;
  logic [31:0]  nxt_pc;
  logic         berr_active_ff,  nxt_berr_active;
  logic         nxt_halted;
  logic         nxt_in_background;
  logic [4:0]   hold_addr_ff,    nxt_hold_addr;
  logic [31:0]  hold_data_ff,    nxt_hold_data;
  cprm_bitop_e  hold_bitop_ff,   nxt_hold_bitop;
  logic         p1_valid_ff,     nxt_p1_valid;
  logic         p1_fault_ff,     nxt_p1_fault;
  logic         p1_mem_ff,       nxt_p1_mem;
  cprm_size_e   p1_size_ff,      nxt_p1_size;
  logic [31:0]  p1_data_ff,      nxt_p1_data;
  cprm_rsp_s    nxt_rsp;
  cprm_bus_s    nxt_bus;

  logic                 mem_we;
  logic [LANES-1:0]     mem_be;
  logic [MEM_AW-1:0]    mem_waddr;
  logic [31:0]          mem_wdata;
  logic [MEM_AW-1:0]    mem_raddr;
  logic [31:0]          mem_rdata_ff;

  logic         take;
  logic         fault;
  logic         user_lvl;
  logic [31:0]  bit_mask;
  logic [31:0]  mem_value;
  logic [31:0]  acc_sum;

  assign supervisor = status_word_ff[SR_S_BIT];
  assign user_lvl   = ~status_word_ff[SR_S_BIT];
  assign req_ready  = (state_ff == ST_RUN);
  assign take       = req_valid && req_ready;

  // Register seven of the address group resolves to the stack pointer of the current level.
  function automatic logic [MEM_AW-1:0] gpr_addr(input logic [3:0] idx, input logic s);
    gpr_addr = {1'b0, idx};
    if (idx == IDX_STACK) begin
      gpr_addr = s ? MEM_SSP : MEM_USP;
    end
  endfunction

  cprm_regmem i_cprm_regmem (
    .clk      (clk),
    .we       (mem_we),
    .be       (mem_be),
    .waddr    (mem_waddr),
    .wdata    (mem_wdata),
    .raddr    (mem_raddr),
    .rdata_ff (mem_rdata_ff)
  );

  // ===========================================================================
  // Privilege check
  // ===========================================================================
  always_comb begin
    fault = 1'b0;
    if (user_lvl) begin
      case (req.op)
        OP_RD_CTL, OP_WR_CTL, OP_EXC_DONE: begin
          fault = 1'b1;
        end
        OP_CHECK_INSN: begin
          fault = req.priv_insn;
        end
        default: begin
          fault = 1'b0;
        end
      endcase
    end
  end

  // ===========================================================================
  // Architectural registers, sequencing and answer pipeline
  // ===========================================================================
  always_comb begin
    bit_mask          = 32'h0000_0001 << hold_data_ff[4:0];
    nxt_state         = state_ff;
    nxt_status_word   = status_word_ff;
    nxt_pc            = pc_ff;
    nxt_vbr           = vbr_ff;
    nxt_sfc           = sfc_ff;
    nxt_dfc           = dfc_ff;
    nxt_berr_active   = berr_active_ff;
    nxt_halted        = halted_ff;
    nxt_in_background = in_background_ff;
    nxt_hold_addr     = hold_addr_ff;
    nxt_hold_data     = hold_data_ff;
    nxt_hold_bitop    = hold_bitop_ff;
    nxt_p1_valid      = take;
    nxt_p1_fault      = take && fault;
    nxt_p1_mem        = 1'b0;
    nxt_p1_size       = SZ_LONG;
    nxt_p1_data       = 32'h0000_0000;
    mem_we            = 1'b0;
    mem_be            = LANE_LONG;
    mem_waddr         = gpr_addr(req.idx, supervisor);
    mem_wdata         = req.wdata;
    mem_raddr         = gpr_addr(req.idx, supervisor);

    if (take && !fault) begin
      case (req.op)
        OP_RD_GPR: begin
          nxt_p1_mem  = 1'b1;
          nxt_p1_size = req.size;
        end
        OP_WR_GPR: begin
          mem_we = 1'b1;
          if (req.idx[ADDR_REG_BIT]) begin
            // Address registers always change whole; a word is sign-extended.
            if (req.size == SZ_WORD) begin
              mem_wdata = {{16{req.wdata[15]}}, req.wdata[15:0]};
            end
          end else if (req.size == SZ_BYTE) begin
            mem_be = LANE_BYTE;
          end else if (req.size == SZ_WORD) begin
            mem_be = LANE_WORD;
          end else if (req.size == SZ_QUAD) begin
            nxt_hold_addr = gpr_addr(req.idx_hi, supervisor);
            nxt_hold_data = req.wdata_hi;
            nxt_state     = ST_QUAD;
          end
        end
        OP_BIT: begin
          nxt_hold_addr  = gpr_addr(req.idx, supervisor);
          nxt_hold_data  = req.wdata;
          nxt_hold_bitop = req.bitop;
          nxt_p1_mem     = 1'b1;
          nxt_state      = ST_RMW;
        end
        OP_RD_CTL: begin
          case (req.ctl)
            CTL_USP: begin
              mem_raddr  = MEM_USP;
              nxt_p1_mem = 1'b1;
            end
            CTL_SSP: begin
              mem_raddr  = MEM_SSP;
              nxt_p1_mem = 1'b1;
            end
            CTL_SR:  nxt_p1_data = {16'h0000, status_word_ff};
            CTL_VBR: nxt_p1_data = vbr_ff;
            CTL_SFC: nxt_p1_data = {29'h0, sfc_ff};
            default: nxt_p1_data = {29'h0, dfc_ff};
          endcase
        end
        OP_WR_CTL: begin
          case (req.ctl)
            CTL_USP: begin
              mem_we    = 1'b1;
              mem_waddr = MEM_USP;
            end
            CTL_SSP: begin
              mem_we    = 1'b1;
              mem_waddr = MEM_SSP;
            end
            CTL_SR:  nxt_status_word = req.wdata[15:0] & SR_IMPL;
            CTL_VBR: nxt_vbr = req.wdata;
            CTL_SFC: nxt_sfc = req.wdata[2:0];
            default: nxt_dfc = req.wdata[2:0];
          endcase
        end
        OP_RD_CCR: begin
          nxt_p1_data = {24'h000000, status_word_ff[CCR_MSB:0]};
        end
        OP_WR_CCR: begin
          nxt_status_word[CCR_MSB:0] = req.wdata[CCR_MSB:0] & SR_IMPL[CCR_MSB:0];
        end
        OP_PC_ADV: begin
          nxt_pc = pc_ff + req.wdata;
        end
        OP_PC_LOAD: begin
          nxt_pc = req.wdata;
        end
        OP_EXC: begin
          // Entry always runs supervised and untraced; the vector address from the base register is answered.
          nxt_p1_data                = vbr_ff + (32'(req.wdata[7:0]) << VEC_SHIFT);
          nxt_status_word[SR_S_BIT]  = 1'b1;
          nxt_status_word[SR_T1_BIT] = 1'b0;
          nxt_status_word[SR_T0_BIT] = 1'b0;
        end
        OP_EXC_DONE: begin
          nxt_status_word = req.wdata[15:0] & SR_IMPL;
          nxt_berr_active = 1'b0;
        end
        OP_BGND: begin
          if (bgnd_enable) begin
            nxt_in_background = 1'b1;
            nxt_state         = ST_STOP;
          end else begin
            nxt_p1_fault = 1'b1;
          end
        end
        default: begin
          nxt_p1_data = 32'h0000_0000;
        end
      endcase
    end

    case (state_ff)
      ST_RMW: begin
        mem_we    = (hold_bitop_ff != BIT_TEST);
        mem_waddr = hold_addr_ff;
        case (hold_bitop_ff)
          BIT_CHG: mem_wdata = mem_rdata_ff ^ bit_mask;
          BIT_CLR: mem_wdata = mem_rdata_ff & ~bit_mask;
          default: mem_wdata = mem_rdata_ff | bit_mask;
        endcase
        nxt_status_word[SR_Z_BIT] = ~|(mem_rdata_ff & bit_mask);
        nxt_state = ST_RUN;
      end
      ST_QUAD: begin
        mem_we    = 1'b1;
        mem_waddr = hold_addr_ff;
        mem_wdata = hold_data_ff;
        nxt_state = ST_RUN;
      end
      ST_STOP: begin
        if (in_background_ff && bgnd_resume) begin
          nxt_in_background = 1'b0;
          nxt_state         = ST_RUN;
        end
      end
      default: begin
        if (bkpt_hit && bgnd_enable) begin
          nxt_in_background = 1'b1;
          nxt_state         = ST_STOP;
        end
      end
    endcase

    // A bus error in the cycle of the return still counts: with berr_active_ff set it stops the core, otherwise the set is applied last.
    if (bus_err) begin
      if (berr_active_ff) begin
        nxt_state = ST_STOP;
        if (bgnd_enable) begin
          nxt_in_background = 1'b1;
        end else begin
          nxt_halted = 1'b1;
        end
      end else begin
        nxt_berr_active = 1'b1;
      end
    end

    mem_value = mem_rdata_ff;
    if (p1_size_ff == SZ_BYTE) begin
      mem_value = {24'h000000, mem_rdata_ff[7:0]};
    end else if (p1_size_ff == SZ_WORD) begin
      mem_value = {{16{mem_rdata_ff[15]}}, mem_rdata_ff[15:0]};
    end
    nxt_rsp.valid = p1_valid_ff;
    nxt_rsp.fault = p1_fault_ff;
    nxt_rsp.data  = p1_mem_ff ? mem_value : p1_data_ff;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff         <= ST_RUN;
      status_word_ff   <= SR_RESET;
      pc_ff            <= PC_RESET;
      vbr_ff           <= VBR_RESET;
      sfc_ff           <= FC_RESET;
      dfc_ff           <= FC_RESET;
      berr_active_ff   <= 1'b0;
      halted_ff        <= 1'b0;
      in_background_ff <= 1'b0;
      hold_addr_ff     <= '0;
      hold_data_ff     <= '0;
      hold_bitop_ff    <= BIT_TEST;
      p1_valid_ff      <= 1'b0;
      p1_fault_ff      <= 1'b0;
      p1_mem_ff        <= 1'b0;
      p1_size_ff       <= SZ_LONG;
      p1_data_ff       <= '0;
      rsp_ff           <= '0;
    end else begin
      state_ff         <= nxt_state;
      status_word_ff   <= nxt_status_word;
      pc_ff            <= nxt_pc;
      vbr_ff           <= nxt_vbr;
      sfc_ff           <= nxt_sfc;
      dfc_ff           <= nxt_dfc;
      berr_active_ff   <= nxt_berr_active;
      halted_ff        <= nxt_halted;
      in_background_ff <= nxt_in_background;
      hold_addr_ff     <= nxt_hold_addr;
      hold_data_ff     <= nxt_hold_data;
      hold_bitop_ff    <= nxt_hold_bitop;
      p1_valid_ff      <= nxt_p1_valid;
      p1_fault_ff      <= nxt_p1_fault;
      p1_mem_ff        <= nxt_p1_mem;
      p1_size_ff       <= nxt_p1_size;
      p1_data_ff       <= nxt_p1_data;
      rsp_ff           <= nxt_rsp;
    end
  end

  // ===========================================================================
  // Memory access: address and function code
  // ===========================================================================
  // The sum is kept at full width; only the low bits leave the core.
  assign acc_sum = acc.base + acc.disp;

  always_comb begin
    nxt_bus.valid = 1'b0;
    nxt_bus.fault = 1'b0;
    nxt_bus.addr  = acc_sum[EXT_ADDR_W-1:0];
    nxt_bus.fc    = {supervisor, acc.prog ? FC_PROG : FC_DATA};
    if (acc.cpu) begin
      nxt_bus.fc = FC_CPU;
    end else if (acc.alt_src) begin
      nxt_bus.fc = sfc_ff;
    end else if (acc.alt_dst) begin
      nxt_bus.fc = dfc_ff;
    end
    if (acc.valid && state_ff != ST_STOP) begin
      if ((acc.alt_src || acc.alt_dst) && user_lvl) begin
        nxt_bus.fault = 1'b1;
      end else begin
        nxt_bus.valid = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_ff <= '0;
    end else begin
      bus_ff <= nxt_bus;
    end
  end

endmodule

/* tb/cprm_properties.sv */
`timescale 1ns/1ns
module cprm_properties
  import cprm_pkg::*;
(
  input wire logic                clk,
  input wire logic                reset_n,
  input wire logic                req_valid,
  input wire cprm_pkg::cprm_req_s req,
  input wire logic                req_ready,
  input wire cprm_pkg::cprm_rsp_s rsp_ff,
  input wire cprm_pkg::cprm_acc_s acc,
  input wire cprm_pkg::cprm_bus_s bus_ff,
  input wire logic                bus_err,
  input wire logic                bkpt_hit,
  input wire logic                bgnd_enable,
  input wire logic                bgnd_resume,
  input wire logic [15:0]         status_word_ff,
  input wire logic [31:0]         pc_ff,
  input wire logic                supervisor,
  input wire logic                halted_ff,
  input wire logic                in_background_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic take;
  logic run;
  assign take = req_valid && req_ready;
  assign run  = !halted_ff && !in_background_ff;
  AST_PRIV_REFUSE: assert property (take && !supervisor &&
    req.op inside {OP_RD_CTL, OP_WR_CTL, OP_EXC_DONE} |-> ##2 rsp_ff.fault && rsp_ff.data == 0)
    else $error("privileged request at user level not refused");
  AST_CHECK_PRIV: assert property (take && req.op == OP_CHECK_INSN && req.priv_insn
    |-> ##2 rsp_ff.valid && rsp_ff.fault == !$past(supervisor, 2))
    else $error("privileged instruction check wrong");
  AST_EXC_ENTRY: assert property (take && req.op == OP_EXC
    |=> supervisor && status_word_ff[15:14] == 2'h0) else $error("exception entry state wrong");
  AST_PC_LOAD: assert property (take && req.op == OP_PC_LOAD
    |=> pc_ff == $past(req.wdata)) else $error("program counter load lost");
  AST_SR_SHAPE: assert property (supervisor == status_word_ff[SR_S_BIT] &&
    (status_word_ff & ~SR_IMPL) == 16'h0) else $error("status word shape wrong");
  AST_FC_CPU: assert property (acc.valid && acc.cpu && run
    |=> bus_ff.valid && bus_ff.fc == FC_CPU) else $error("cpu space code wrong");
  AST_FC_AUTO: assert property (acc.valid && run && !(acc.cpu || acc.alt_src || acc.alt_dst)
    |=> bus_ff.fc == {$past(supervisor), $past(acc.prog) ? FC_PROG : FC_DATA})
    else $error("automatic space code wrong");
  AST_ADDR: assert property (acc.valid |=> !bus_ff.valid ||
    bus_ff.addr == 24'($past(acc.base) + $past(acc.disp))) else $error("address sum wrong");
  AST_ALT_USER: assert property (acc.valid && run && !supervisor && !acc.cpu &&
    (acc.alt_src || acc.alt_dst) |=> bus_ff.fault && !bus_ff.valid)
    else $error("alternate space at user level not refused");
  AST_HALT_HOLD: assert property (halted_ff |-> !req_ready ##1 halted_ff)
    else $error("halt not held");
  AST_BKPT: assert property (bkpt_hit && bgnd_enable && req_ready |=> in_background_ff)
    else $error("breakpoint did not enter background");
endmodule

bind cprm_core cprm_properties i_cprm_properties (.clk, .reset_n, .req_valid, .req, .req_ready,
  .rsp_ff, .acc, .bus_ff, .bus_err, .bkpt_hit, .bgnd_enable, .bgnd_resume, .status_word_ff,
  .pc_ff, .supervisor, .halted_ff, .in_background_ff);

/* tb/cpu_privilege_register_model_tb_top.sv */
`timescale 1ns/1ns
module cpu_privilege_register_model_tb_top;
  import cprm_pkg::*;
  `define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
  logic        clk, reset_n, req_valid, req_ready, supervisor, halted_ff, in_background_ff;
  logic        bgnd_enable;
  logic [2:0]  ev;
  cprm_req_s   req;
  cprm_rsp_s   rsp_ff;
  cprm_acc_s   acc;
  cprm_bus_s   bus_ff;
  logic [15:0] status_word_ff;
  logic [31:0] pc_ff, v, w, m, d [16];
  logic [32:0] e, exp_q [$];
  logic [31:0] msk_q [$];
  int          fails, num_checks;

  cprm_core i_cprm_core (.clk(clk), .reset_n(reset_n), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_ff(rsp_ff), .acc(acc), .bus_ff(bus_ff), .bus_err(ev[0]),
    .bkpt_hit(ev[1]), .bgnd_enable(bgnd_enable), .bgnd_resume(ev[2]),
    .status_word_ff(status_word_ff), .pc_ff(pc_ff), .supervisor(supervisor),
    .halted_ff(halted_ff), .in_background_ff(in_background_ff));

  // ====================
  // Drivers
  // ====================
  function automatic cprm_req_s mk(cprm_op_e o, cprm_size_e s, logic [3:0] i, cprm_ctl_e c,
                                   logic [31:0] x);
    return '{op:o, size:s, idx:i, idx_hi:4'h2, ctl:c, bitop:BIT_SET, priv_insn:1'b1,
             wdata:x, wdata_hi:~x};
  endfunction

  // The expectation is queued at the taking edge; the answer arrives one edge later.
  task automatic tx(input cprm_req_s x, input logic [32:0] ex, input logic [31:0] mx);
    int n;
    n = 0;
    req <= x;
    req_valid <= 1'b1;
    do begin
      @(negedge clk);
      n++;
    end while (req_ready !== 1'b1 && n < 20);
    @(posedge clk);
    exp_q.push_back(ex);
    msk_q.push_back(mx);
  endtask

  task automatic wr(input logic [3:0] i, input cprm_size_e s, input logic [31:0] x);
    tx(mk(OP_WR_GPR, s, i, CTL_USP, x), 33'h0, 32'h0);
  endtask

  task automatic rd(input logic [3:0] i, input cprm_size_e s, input logic [31:0] x);
    tx(mk(OP_RD_GPR, s, i, CTL_USP, 32'h0), {1'b0, x}, '1);
  endtask

  task automatic ctl(input cprm_op_e o, input cprm_ctl_e c, input logic [31:0] x, input logic f);
    tx(mk(o, SZ_LONG, 4'h0, c, x), {f, (o == OP_RD_CTL && !f) ? x : 32'h0},
       (o == OP_RD_CTL || f) ? '1 : 32'h0);
  endtask

  task automatic settle;
    req_valid <= 1'b0;
    @(posedge clk);
    @(negedge clk);
  endtask

  task automatic pulse(input int k);
    @(posedge clk);
    ev[k] <= 1'b1;
    @(posedge clk);
    ev[k] <= 1'b0;
  endtask

  task automatic ac(input logic c, p, s, t, input logic [2:0] fc, input logic ok, fl);
    logic [31:0] b, o, sum;
    b = $urandom;
    o = $urandom;
    sum = b + o;
    @(posedge clk);
    acc <= '{valid:1'b1, prog:p, cpu:c, alt_src:s, alt_dst:t, base:b, disp:o};
    @(posedge clk);
    acc.valid <= 1'b0;
    @(negedge clk);
    `CHK({bus_ff.valid, bus_ff.fault}, {ok, fl})
    if (ok) `CHK({bus_ff.fc, bus_ff.addr}, {fc, sum[23:0]})
  endtask

  task automatic test_done;
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ====================
  // Answer monitor
  // ====================
  always @(negedge clk) begin
    if (rsp_ff.valid === 1'b1) begin
      `CHK(exp_q.size() > 0, 1'b1)
      if (exp_q.size() > 0) begin
        e = exp_q.pop_front();
        m = msk_q.pop_front();
        `CHK({rsp_ff.fault, rsp_ff.data & m}, e)
      end
    end
  end

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    #200000;
    fails++;
    test_done;
  end

  initial begin
    reset_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    acc = '0;
    ev = 3'h0;
    bgnd_enable = 1'b0;
    fails = 0;
    num_checks = 0;
    v = $urandom(32'he48cbabc);
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 15; i++) begin
      d[i] = $urandom;
      wr(i[3:0], SZ_LONG, d[i]);
    end
    for (int i = 0; i < 15; i++) rd(i[3:0], SZ_LONG, d[i]);
    wr(4'h3, SZ_BYTE, 32'hffff_ff5a);
    rd(4'h3, SZ_LONG, {d[3][31:8], 8'h5a});
    wr(4'h4, SZ_WORD, 32'h0000_8001);
    rd(4'h4, SZ_LONG, {d[4][31:16], 16'h8001});
    rd(4'h4, SZ_WORD, 32'hffff_8001);
    rd(4'h4, SZ_BYTE, 32'h0000_0001);
    wr(4'h9, SZ_WORD, 32'h0000_8001);
    rd(4'h9, SZ_LONG, 32'hffff_8001);
    v = $urandom;
    wr(4'h1, SZ_QUAD, v);
    rd(4'h1, SZ_LONG, v);
    rd(4'h2, SZ_LONG, ~v);
    tx(mk(OP_BIT, SZ_LONG, 4'h5, CTL_USP, 32'h5), {1'b0, d[5]}, '1);
    settle;
    `CHK(status_word_ff[2], ~d[5][5])
    @(posedge clk);
    rd(4'h5, SZ_LONG, d[5] | 32'h20);
    $display("test registers done");
    w = $urandom;
    wr(4'hf, SZ_LONG, v);
    ctl(OP_WR_CTL, CTL_USP, w, 1'b0);
    ctl(OP_RD_CTL, CTL_SSP, v, 1'b0);
    ctl(OP_WR_CTL, CTL_VBR, 32'h0001_0000, 1'b0);
    ctl(OP_WR_CTL, CTL_SFC, 32'h5, 1'b0);
    ctl(OP_WR_CTL, CTL_DFC, 32'h3, 1'b0);
    ctl(OP_RD_CTL, CTL_SFC, 32'h5, 1'b0);
    tx(mk(OP_CHECK_INSN, SZ_LONG, 4'h0, CTL_USP, 32'h0), 33'h0, 32'h0);
    settle;
    ac(1'b1, 1'b0, 1'b0, 1'b0, FC_CPU, 1'b1, 1'b0);
    ac(1'b0, 1'b1, 1'b0, 1'b0, {1'b1, FC_PROG}, 1'b1, 1'b0);
    ac(1'b0, 1'b0, 1'b0, 1'b0, {1'b1, FC_DATA}, 1'b1, 1'b0);
    ac(1'b0, 1'b0, 1'b1, 1'b0, 3'h5, 1'b1, 1'b0);
    ac(1'b0, 1'b0, 1'b0, 1'b1, 3'h3, 1'b1, 1'b0);
    @(posedge clk);
    ctl(OP_WR_CTL, CTL_SR, 32'h0000_8005, 1'b0);
    settle;
    `CHK(status_word_ff, 16'h8005)
    ac(1'b0, 1'b1, 1'b0, 1'b0, {1'b0, FC_PROG}, 1'b1, 1'b0);
    ac(1'b0, 1'b0, 1'b1, 1'b0, 3'h0, 1'b0, 1'b1);
    @(posedge clk);
    rd(4'hf, SZ_LONG, w);
    tx(mk(OP_CHECK_INSN, SZ_LONG, 4'h0, CTL_USP, 32'h0), {1'b1, 32'h0}, '1);
    ctl(OP_RD_CTL, CTL_VBR, 32'h0, 1'b1);
    ctl(OP_WR_CTL, CTL_VBR, 32'h0, 1'b1);
    tx(mk(OP_RD_CCR, SZ_LONG, 4'h0, CTL_USP, 32'h0), {1'b0, 32'h5}, '1);
    tx(mk(OP_WR_CCR, SZ_LONG, 4'h0, CTL_USP, 32'hff), 33'h0, 32'h0);
    tx(mk(OP_RD_CCR, SZ_LONG, 4'h0, CTL_USP, 32'h0), {1'b0, 32'h1f}, '1);
    tx(mk(OP_EXC, SZ_LONG, 4'h0, CTL_USP, {24'h0, v[7:0]}),
       {1'b0, 32'h0001_0000 + {22'h0, v[7:0], 2'h0}}, '1);
    settle;
    `CHK(status_word_ff, 16'h201f)
    @(posedge clk);
    ctl(OP_RD_CTL, CTL_VBR, 32'h0001_0000, 1'b0);
    rd(4'hf, SZ_LONG, v);
    w = $urandom;
    tx(mk(OP_PC_LOAD, SZ_LONG, 4'h0, CTL_USP, w), 33'h0, '1);
    tx(mk(OP_PC_ADV, SZ_LONG, 4'h0, CTL_USP, 32'h4), 33'h0, '1);
    settle;
    `CHK(pc_ff, w + 32'h4)
    $display("test privilege done");
    @(posedge clk);
    bgnd_enable <= 1'b1;
    pulse(1);
    settle;
    `CHK({in_background_ff, req_ready}, 2'b10)
    pulse(2);
    settle;
    `CHK(in_background_ff, 1'b0)
    @(posedge clk);
    bgnd_enable <= 1'b0;
    tx(mk(OP_BGND, SZ_LONG, 4'h0, CTL_USP, 32'h0), {1'b1, 32'h0}, 32'h0);
    settle;
    pulse(0);
    @(posedge clk);
    tx(mk(OP_EXC_DONE, SZ_LONG, 4'h0, CTL_USP, 32'h2700), 33'h0, 32'h0);
    settle;
    pulse(0);
    pulse(0);
    settle;
    `CHK({halted_ff, req_ready}, 2'b10)
    ac(1'b1, 1'b0, 1'b0, 1'b0, FC_CPU, 1'b0, 1'b0);
    repeat (3) @(posedge clk);
    `CHK(halted_ff, 1'b1)
    $display("test faults done");
    test_done;
  end
endmodule
